//--- rtl/iopcs_pkg.sv
package iopcs_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_TOS    = 8'h04;
  localparam logic [7:0]  REG_CFG    = 8'h08;
  localparam logic [7:0]  REG_STAT   = 8'h0c;
  localparam logic [7:0]  REG_PTR    = 8'h10;
  // ==========================================================
  // Field positions
  localparam int          CTL_CODE_HI = 14;
  localparam int          CTL_CODE_LO = 12;
  localparam int          CFG_SEL     = 0;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_DONE   = 1;
  localparam int          STAT_RES_LO = 16;
  localparam int          CW_DC       = 15;
  localparam int          CW_OP_HI    = 14;
  localparam int          CW_OP_LO    = 12;
  localparam int          CW_COND     = 11;
  // ==========================================================
  // Reset values and codes
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] TOS_RST    = 16'h0000;
  localparam logic        SEL_RST    = 1'b0;
  localparam logic [2:0]  START_CODE = 3'h1;
  localparam logic [2:0]  OP_JUMP    = 3'h0;
  localparam logic [2:0]  OP_RESID   = 3'h1;
  localparam logic [2:0]  OP_INTR    = 3'h2;
  localparam logic [2:0]  OP_END     = 3'h3;
  localparam logic [2:0]  OP_CTL     = 3'h4;
  localparam logic [2:0]  OP_SENSE   = 3'h5;
  localparam logic [2:0]  OP_WRITE   = 3'h6;
  localparam logic [2:0]  OP_READ    = 3'h7;
  localparam logic [3:0]  DCMD_START = 4'h8;
  localparam logic [3:0]  DCMD_WRWD  = 4'h9;
  localparam logic [3:0]  DCMD_RDWD  = 4'ha;
  // ==========================================================
  typedef enum logic [3:0] {
    S_IDLE, S_PUT_TOS, S_START, S_GET_PTR, S_FETCH_CW, S_FETCH_AW,
    S_PUT_PTR, S_DECODE, S_DEV_OP, S_MEM_RD, S_DEV_WORD, S_MEM_WR,
    S_PUT_AW, S_WB_PTR
  } iopcs_st_type;
endpackage

//--- rtl/iopcs_sequencer.sv
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
module iopcs_sequencer
  import iopcs_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Main memory word port
  output      logic        mem_req,
  output      logic        mem_we,
  output      logic [15:0] mem_addr,
  output      logic [15:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  // Device controller port
  output      logic        dev_req,
  output      logic [7:0]  dev_num,
  output      logic [3:0]  dev_code,
  output      logic [27:0] dev_wdata,
  input  wire logic        dev_ack,
  input  wire logic [15:0] dev_rdata,
  input  wire logic        dev_cond,
  // Status
  output      logic        busy
);
  // ==========================================================
  // State
  typedef struct packed {
    iopcs_st_type st;
    logic [15:0]  ctrl;
    logic [15:0]  top_stack_value;
    logic         sel;
    logic         busy;
    logic         done;
    logic [31:0]  prdata;
    logic         perr;
    logic [7:0]   dev;
    logic [15:0]  ptr;
    logic [15:0]  ent;
    logic [15:0]  cw;
    logic [15:0]  aw;
    logic [11:0]  cnt;
    logic [15:0]  maddr;
    logic [15:0]  mwd;
    logic [3:0]   dcode;
    logic [27:0]  dwd;
    logic         chain;
    logic [2:0]   lastop;
    logic         jmp;
  } iopcs_regs_type;

  iopcs_regs_type r_q, r_d;
  logic [2:0]  op;
  logic [15:0] device_reference_table;
  logic        setup;
  logic        wr;
  logic        go_fetch;
  logic        go_end;
  logic        word_done;
  logic        is_mem;
  logic        chained;

  assign op    = r_q.cw[CW_OP_HI:CW_OP_LO];
  assign device_reference_table   = {6'h00, r_q.dev, 2'b00};
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite;

  // ==========================================================
  // Outputs
  assign is_mem = r_q.st inside {S_PUT_TOS, S_GET_PTR, S_FETCH_CW,
                  S_FETCH_AW, S_PUT_PTR, S_MEM_RD, S_MEM_WR, S_PUT_AW,
                  S_WB_PTR};
  assign mem_req   = is_mem;
  assign mem_we    = r_q.st inside {S_PUT_TOS, S_PUT_PTR, S_MEM_WR,
                     S_PUT_AW, S_WB_PTR};
  assign mem_addr  = r_q.maddr;
  assign mem_wdata = r_q.mwd;
  assign dev_req   = r_q.st inside {S_START, S_DEV_OP, S_DEV_WORD};
  assign dev_num   = r_q.dev;
  assign dev_code  = r_q.dcode;
  assign dev_wdata = r_q.dwd;
  assign busy      = r_q.busy;
  assign prdata    = r_q.prdata;
  assign pslverr   = r_q.perr;
  // Zero wait states: read data is latched in the setup cycle
  assign pready    = 1'b1;

  // ==========================================================
  // Next state
  always_comb begin
    r_d       = r_q;
    go_fetch  = 1'b0;
    go_end    = 1'b0;
    word_done = 1'b0;
    chained   = r_q.chain && (r_q.lastop == op);
    if (setup) begin
      r_d.perr   = 1'b0;
      r_d.prdata = 32'h0000_0000;
      unique case (paddr)
        REG_CTRL: r_d.prdata[15:0] = r_q.ctrl;
        REG_TOS:  r_d.prdata[15:0] = r_q.top_stack_value;
        REG_CFG:  r_d.prdata[CFG_SEL] = r_q.sel;
        REG_STAT: r_d.prdata = {4'h0, r_q.cnt, 14'h0000, r_q.done,
                                r_q.busy};
        REG_PTR:  r_d.prdata[15:0] = r_q.ptr;
        default:  r_d.perr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        REG_CTRL: r_d.ctrl = pwdata[15:0];
        REG_TOS:  r_d.top_stack_value  = pwdata[15:0];
        REG_CFG:  r_d.sel  = pwdata[CFG_SEL];
        REG_STAT: if (pwdata[STAT_DONE]) r_d.done = 1'b0;
        default: ;
      endcase
    end
    unique case (r_q.st)
      S_IDLE: begin
        // Start is ignored while a program runs
        if (wr && paddr == REG_CTRL &&
            pwdata[CTL_CODE_HI:CTL_CODE_LO] == START_CODE) begin
          r_d.dev   = pwdata[7:0];
          r_d.maddr = {6'h00, pwdata[7:0], 2'b00};
          r_d.mwd   = r_q.top_stack_value;
          r_d.busy  = 1'b1;
          r_d.chain = 1'b0;
          r_d.cnt   = 12'h000;
          r_d.st    = S_PUT_TOS;
        end
      end
      S_PUT_TOS: if (mem_ack) begin
        r_d.dcode = DCMD_START;
        r_d.dwd   = 28'h0000000;
        r_d.st    = S_START;
      end
      S_START: if (dev_ack) begin
        r_d.maddr = device_reference_table;
        r_d.st    = S_GET_PTR;
      end
      S_GET_PTR: if (mem_ack) begin
        r_d.ptr   = mem_rdata;
        r_d.maddr = mem_rdata;
        r_d.st    = S_FETCH_CW;
      end
      S_FETCH_CW: if (mem_ack) begin
        r_d.cw    = mem_rdata;
        r_d.ent   = r_q.ptr;
        r_d.maddr = r_q.ptr + 16'h0001;
        r_d.st    = S_FETCH_AW;
      end
      S_FETCH_AW: if (mem_ack) begin
        r_d.aw  = mem_rdata;
        r_d.ptr = r_q.ptr + 16'h0002;
        if (r_q.sel) begin
          r_d.st = S_DECODE;
        end else begin
          // Multiplexer keeps the table copy current
          r_d.maddr = device_reference_table;
          r_d.mwd   = r_q.ptr + 16'h0002;
          r_d.st    = S_PUT_PTR;
        end
      end
      S_PUT_PTR: if (mem_ack) begin
        r_d.jmp = 1'b0;
        r_d.st  = r_q.jmp ? S_GET_PTR : S_DECODE;
        r_d.maddr = r_q.jmp ? device_reference_table : r_q.maddr;
      end
      S_DECODE: begin
        r_d.dcode = {1'b0, op};
        r_d.dwd   = {r_q.cw[11:0], r_q.aw};
        r_d.maddr = r_q.ent + 16'h0001;
        r_d.chain = 1'b0;
        unique case (op)
          OP_JUMP: begin
            if (r_q.cw[CW_COND]) begin
              r_d.st = S_DEV_OP;
            end else begin
              r_d.ptr  = r_q.aw;
              go_fetch = 1'b1;
            end
          end
          OP_RESID: begin
            r_d.mwd = {4'h0, r_q.cnt};
            r_d.st  = S_PUT_AW;
          end
          OP_WRITE, OP_READ: begin
            r_d.cnt = r_q.cw[11:0];
            if (chained) begin
              // Device already set up by the preceding order
              r_d.maddr = r_q.aw;
              r_d.dcode = DCMD_RDWD;
              r_d.st    = (op == OP_WRITE) ? S_MEM_RD : S_DEV_WORD;
            end else begin
              r_d.st = S_DEV_OP;
            end
          end
          default: r_d.st = S_DEV_OP;
        endcase
      end
      S_DEV_OP: if (dev_ack) begin
        unique case (op)
          OP_JUMP: begin
            if (dev_cond) r_d.ptr = r_q.aw;
            go_fetch = 1'b1;
          end
          OP_END, OP_SENSE: begin
            r_d.mwd = dev_rdata;
            r_d.st  = S_PUT_AW;
          end
          OP_WRITE: begin
            r_d.maddr = r_q.aw;
            r_d.st    = S_MEM_RD;
          end
          OP_READ: begin
            r_d.dcode = DCMD_RDWD;
            r_d.st    = S_DEV_WORD;
          end
          default: go_fetch = 1'b1;
        endcase
      end
      S_MEM_RD: if (mem_ack) begin
        r_d.dwd   = {12'h000, mem_rdata};
        r_d.dcode = DCMD_WRWD;
        r_d.st    = S_DEV_WORD;
      end
      S_DEV_WORD: if (dev_ack) begin
        if (op == OP_READ) begin
          r_d.mwd   = dev_rdata;
          r_d.maddr = r_q.aw;
          r_d.st    = S_MEM_WR;
        end else begin
          word_done = 1'b1;
        end
      end
      S_MEM_WR: if (mem_ack) word_done = 1'b1;
      S_PUT_AW: if (mem_ack) begin
        if (op != OP_END) begin
          go_fetch = 1'b1;
        end else if (r_q.sel) begin
          r_d.maddr = device_reference_table;
          r_d.mwd   = r_q.ptr;
          r_d.st    = S_WB_PTR;
        end else begin
          go_end = 1'b1;
        end
      end
      S_WB_PTR: if (mem_ack) go_end = 1'b1;
    endcase
    if (word_done) begin
      r_d.aw  = r_q.aw + 16'h0001;
      r_d.cnt = r_q.cnt + 12'h001;
      if (r_q.cnt == 12'hfff) begin
        r_d.chain  = r_q.cw[CW_DC];
        r_d.lastop = op;
        go_fetch   = 1'b1;
      end else begin
        r_d.maddr = r_q.aw + 16'h0001;
        r_d.dcode = DCMD_RDWD;
        r_d.st    = (op == OP_WRITE) ? S_MEM_RD : S_DEV_WORD;
      end
    end
    if (go_fetch) begin
      if (r_q.sel) begin
        r_d.maddr = r_d.ptr;
        r_d.st    = S_FETCH_CW;
      end else if (r_d.ptr != r_q.ptr) begin
        // A taken jump must reach the table before the next fetch
        r_d.maddr = device_reference_table;
        r_d.mwd   = r_d.ptr;
        r_d.jmp   = 1'b1;
        r_d.st    = S_PUT_PTR;
      end else begin
        r_d.maddr = device_reference_table;
        r_d.st    = S_GET_PTR;
      end
    end
    if (go_end) begin
      r_d.st   = S_IDLE;
      r_d.busy = 1'b0;
      r_d.done = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q      <= '0;
      r_q.st   <= S_IDLE;
      r_q.ctrl <= CTRL_RST;
      r_q.top_stack_value  <= TOS_RST;
      r_q.sel  <= SEL_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence put_tos_s;
    r_q.st == S_PUT_TOS && mem_ack;
  endsequence
  sequence start_cmd_s;
    dev_req && dev_code == DCMD_START;
  endsequence

  start_put_a: assert property (
    r_q.st == S_IDLE && wr && paddr == REG_CTRL &&
    pwdata[CTL_CODE_HI:CTL_CODE_LO] == START_CODE |=> mem_req && mem_we
    && mem_addr == {6'h00, $past(pwdata[7:0]), 2'b00}
    && mem_wdata == $past(r_q.top_stack_value))
    else $error("start did not store pointer");
  start_dev_a: assert property (put_tos_s |=> start_cmd_s)
    else $error("start command not issued");
  ctrl_load_a: assert property (
    wr && paddr == REG_CTRL |=> r_q.ctrl == $past(pwdata[15:0]))
    else $error("control register not loaded");
  drt_addr_a: assert property (
    r_q.st == S_GET_PTR |-> mem_addr == {6'h00, dev_num, 2'b00})
    else $error("table address wrong");
  fetch_pair_a: assert property (
    r_q.st == S_FETCH_CW && mem_ack |=> r_q.st == S_FETCH_AW
    && mem_addr == $past(mem_addr) + 16'h0001)
    else $error("address word not next");
  ptr_adv_a: assert property (
    r_q.st == S_FETCH_AW && mem_ack |=> r_q.ptr == $past(r_q.ptr) + 16'h0002)
    else $error("pointer did not advance");
  ctl_bits_a: assert property (
    dev_req && dev_code == {1'b0, OP_CTL}
    |-> dev_wdata == {r_q.cw[11:0], r_q.aw})
    else $error("control bits wrong");
  sense_ret_a: assert property (
    r_q.st == S_DEV_OP && dev_ack && op == OP_SENSE
    |=> mem_we && mem_wdata == $past(dev_rdata)
    && mem_addr == r_q.ent + 16'h0001)
    else $error("sense status not stored");
  wb_ptr_a: assert property (
    r_q.st == S_WB_PTR |-> mem_wdata == r_q.ptr
    && mem_addr == {6'h00, dev_num, 2'b00})
    else $error("pointer write-back wrong");
  cnt_step_a: assert property (
    word_done |=> r_q.cnt == $past(r_q.cnt) + 12'h001)
    else $error("count not stepped");
endmodule

//--- verif/iopcs_far_model.sv
`timescale 1ns/1ns
// ==========================================================
// Memory and device controller stand-in
module iopcs_far_model
  import iopcs_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Memory side
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output      logic        mem_ack,
  output      logic [15:0] mem_rdata,
  // Device side
  input  wire logic        dev_req,
  input  wire logic [7:0]  dev_num,
  input  wire logic [3:0]  dev_code,
  input  wire logic [27:0] dev_wdata,
  output      logic        dev_ack,
  output      logic [15:0] dev_rdata,
  output      logic        dev_cond,
  // Bench controls
  input  wire logic [15:0] dev_status,
  input  wire logic        cond_take
);
  logic [15:0] mem [256];
  logic [1:0]  mwait;
  logic [1:0]  dwait;
  logic [63:0] code_log;
  logic [31:0] wr_log;
  logic [27:0] ctl_data;
  logic [7:0]  start_num;
  logic [15:0] rd_word;

  // Answers come late at random; released data is scrambled so a
  // stale value is never mistaken for a fresh one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      mwait     <= 2'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (mwait == 2'h0) begin
          mem_ack   <= 1'b1;
          mem_rdata <= mem[mem_addr[7:0]];
          if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
          mwait     <= 2'($urandom);
        end else begin
          mwait <= mwait - 2'h1;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_ack   <= 1'b0;
      dev_rdata <= 16'h0000;
      dev_cond  <= 1'b0;
      dwait     <= 2'h0;
      code_log  <= 64'h0;
      wr_log    <= 32'h0;
      ctl_data  <= 28'h0;
      start_num <= 8'h00;
      rd_word   <= 16'h0100;
    end else begin
      dev_ack   <= 1'b0;
      dev_rdata <= ~dev_rdata;
      dev_cond  <= ~dev_cond;
      if (dev_req && !dev_ack) begin
        if (dwait == 2'h0) begin
          dev_ack  <= 1'b1;
          dev_cond <= cond_take;
          dwait    <= 2'($urandom);
          code_log <= {code_log[59:0], dev_code};
          if (dev_code == DCMD_RDWD) begin
            dev_rdata <= rd_word;
            rd_word   <= rd_word + 16'h1;
          end else begin
            dev_rdata <= dev_status;
          end
          if (dev_code == DCMD_WRWD) begin
            wr_log <= {wr_log[15:0], dev_wdata[15:0]};
          end
          if (dev_code == {1'b0, OP_CTL}) ctl_data <= dev_wdata;
          if (dev_code == DCMD_START) start_num <= dev_num;
        end else begin
          dwait <= dwait - 2'h1;
        end
      end
    end
  end
endmodule

//--- verif/tb.sv
`timescale 1ns/1ns
module tb
  import iopcs_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, dev_num;
  logic [31:0] pwdata, prdata;
  logic        mem_req, mem_we, mem_ack, dev_req, dev_ack, dev_cond;
  logic        busy, cond_take;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, dev_rdata, dev_status;
  logic [3:0]  dev_code;
  logic [27:0] dev_wdata;
  int          fails, compares, cyc;
  // Program: control, sense, write 2, chained read 1+1, residue,
  // jump over a trap, interrupt, end with interrupt
  localparam logic [15:0] PROG [20] = '{
    16'h4abc, 16'h1234, 16'h5000, 16'h0000, 16'h6ffe, 16'h0080,
    16'hffff, 16'h0090, 16'h7fff, 16'h00a0, 16'h1000, 16'hffff,
    16'h0000, 16'h0050, 16'h6fff, 16'h0080, 16'h2000, 16'h0000,
    16'h3800, 16'h0000};

  iopcs_sequencer dut (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata),
    .dev_req   (dev_req),
    .dev_num   (dev_num),
    .dev_code  (dev_code),
    .dev_wdata (dev_wdata),
    .dev_ack   (dev_ack),
    .dev_rdata (dev_rdata),
    .dev_cond  (dev_cond),
    .busy      (busy)
  );
  iopcs_far_model far (
    .pclk       (pclk),
    .presetn    (presetn),
    .mem_req    (mem_req),
    .mem_we     (mem_we),
    .mem_addr   (mem_addr),
    .mem_wdata  (mem_wdata),
    .mem_ack    (mem_ack),
    .mem_rdata  (mem_rdata),
    .dev_req    (dev_req),
    .dev_num    (dev_num),
    .dev_code   (dev_code),
    .dev_wdata  (dev_wdata),
    .dev_ack    (dev_ack),
    .dev_rdata  (dev_rdata),
    .dev_cond   (dev_cond),
    .dev_status (dev_status),
    .cond_take  (cond_take)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================================
  // Reporting
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Device codes of one run, oldest in the highest nonzero nibble
  function automatic logic [63:0] exp_log(input logic sel);
    logic [63:0] l;
    l = 64'({DCMD_START, 1'b0, OP_CTL, 1'b0, OP_SENSE, 1'b0, OP_WRITE,
             DCMD_WRWD, DCMD_WRWD, 1'b0, OP_READ, DCMD_RDWD, DCMD_RDWD});
    if (sel) l = {l[59:0], 1'b0, OP_JUMP};
    return {l[55:0], 1'b0, OP_INTR, 1'b0, OP_END};
  endfunction

  // Hangs are cut short well beyond the longest run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  // ==========================================================
  // APB master
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================
  // One program run; sel picks selector channel and conditional jump
  task automatic run(input logic sel);
    logic [7:0]  d;
    logic [15:0] w0, w1, st;
    logic [31:0] r;
    logic        e;
    d  = 8'(1 + $urandom % 15);
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    st = 16'($urandom);
    for (int i = 0; i < 20; i++) far.mem[8'h40 + i] = PROG[i];
    if (sel) far.mem[8'h4c] = 16'h0800;
    far.mem[8'h80] = w0;
    far.mem[8'h81] = w1;
    dev_status <= st;
    cond_take  <= sel;
    apb(1'b1, REG_CFG, {31'h0, sel}, r, e);
    apb(1'b1, REG_TOS, 32'h40, r, e);
    apb(1'b1, REG_CTRL, {17'h0, START_CODE, 4'h0, d}, r, e);
    // A second start while busy must be ignored
    apb(1'b1, REG_CTRL, {17'h0, START_CODE, 4'h0, d ^ 8'h10}, r, e);
    chk("busy pin", 1, busy);
    r = 32'h0;
    while (r[STAT_DONE] !== 1'b1) apb(1'b0, REG_STAT, 32'h0, r, e);
    chk("busy", 0, r[STAT_BUSY]);
    chk("busy pin", 0, busy);
    chk("start dev", d, far.start_num);
    chk("order log", exp_log(sel), far.code_log);
    chk("control", 28'habc1234, far.ctl_data);
    chk("sense", st, far.mem[8'h43]);
    chk("write words", {w0, w1}, far.wr_log);
    chk("read word 1", 16'h0100, far.mem[8'h90]);
    chk("read word 2", 16'h0101, far.mem[8'ha0]);
    chk("residue", 16'h0000, far.mem[8'h4b]);
    chk("end status", st, far.mem[8'h53]);
    chk("table ptr", 16'h0054, far.mem[{d[5:0], 2'b00}]);
    apb(1'b0, REG_PTR, 32'h0, r, e);
    chk("pointer reg", 32'h54, r);
    apb(1'b1, REG_STAT, 32'h2, r, e);
    apb(1'b0, REG_STAT, 32'h0, r, e);
    chk("status clear", 0, r);
    $display("program run sel=%0d done", sel);
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dev_status = 16'h0;
    cond_take = 1'b0;
    void'($urandom(67));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, r, e);
      chk("reset value", 0, r);
      chk("mapped err", 0, e);
    end
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, r);
    $display("register reset test done");
    run(1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_STAT, 32'h0, r, e);
    chk("reset status", 0, r);
    run(1'b1);
    print_verdict();
  end
endmodule
